// File: rtl/dcp_pkg.sv
package dcp_pkg;

   // ==========================================================================
   // program counter and vectors
   localparam logic [15:0] DCP_RESET_VECTOR = 16'hff80;
   // nmi trap location; plain default, to be aligned with the vector table
   localparam logic [15:0] DCP_NMI_VECTOR   = 16'hff88;
   // internal rom occupies the top 16k words of program space
   localparam logic [15:0] DCP_ROM_BASE     = 16'hc000;

   // ==========================================================================
   // synchronised pin positions and their values while RST is high
   localparam int          DCP_PIN_W        = 6;
   localparam int          DCP_PIN_RESET_N  = 0;
   localparam int          DCP_PIN_ROM_SEL  = 1;
   localparam int          DCP_PIN_NMI_N    = 2;
   localparam int          DCP_PIN_BRANCH_N = 3;
   localparam int          DCP_PIN_OUT_EN_N = 4;
   localparam int          DCP_PIN_HOLD_N   = 5;
   localparam logic [5:0]  DCP_PIN_IDLE     = 6'h2c;

   // ==========================================================================
   // reset values
   localparam logic        DCP_FLAG_RESET   = 1'h1;
   localparam logic        DCP_ROM_RESET    = 1'h0;

   // ==========================================================================
   // types
   typedef enum logic [1:0]
   {
      DCP_RUN_RESET = 2'h0,
      DCP_RUN_EXEC  = 2'h1,
      DCP_RUN_HOLD  = 2'h3
   } dcp_run_t;

   typedef enum logic [1:0]
   {
      DCP_SPACE_DATA = 2'h0,
      DCP_SPACE_PROG = 2'h1,
      DCP_SPACE_IO   = 2'h2
   } dcp_space_t;

   typedef struct packed
   {
      logic       valid;
      dcp_space_t space;
   } dcp_access_t;

   typedef struct packed
   {
      logic ds_n;
      logic ps_n;
      logic is_n;
      logic strb_n;
   } dcp_sel_t;

   localparam dcp_sel_t DCP_SEL_IDLE = 4'hf;

   typedef struct packed
   {
      dcp_sel_t pin;
      logic     oe;
   } dcp_bus_out_t;

endpackage

// File: rtl/dcp_sync.sv
`timescale 1ns/100ps

module dcp_sync
   import dcp_pkg::*;
#(
   parameter int             W       = 1,
   parameter logic [W-1:0]   RST_VAL = '0
)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // pins in, synchronised levels out
   input  wire logic [W-1:0] pin,
   output      logic [W-1:0] sync
);

   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dcp_sync_state_t;

   dcp_sync_state_t q;
   dcp_sync_state_t d;

   // ==========================================================================
   // two stages; only the second stage is visible outside
   always_comb
   begin
      d    = q;
      d.s1 = pin;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= {RST_VAL, RST_VAL};
      end
      else
      begin
         q <= d;
      end
   end

   assign sync = q.s2;

endmodule

// File: rtl/dcp_bus_sel.sv
`timescale 1ns/100ps

module dcp_bus_sel
   import dcp_pkg::*;
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // access request and bus ownership
   input  wire dcp_access_t  access,
   input  wire logic         hold,
   input  wire logic         out_en_n,
   // registered pin drive
   output      dcp_bus_out_t bus
);

   dcp_bus_out_t q;
   dcp_bus_out_t d;

   // ==========================================================================
   // selects and strobe follow the access one cycle later, in step with the
   // registered address, so the low period matches valid address
   always_comb
   begin
      d     = q;
      d.pin = DCP_SEL_IDLE;
      if (access.valid && !hold)
      begin
         unique case (access.space)
            DCP_SPACE_DATA:
            begin
               d.pin.ds_n   = 1'b0;
               d.pin.strb_n = 1'b0;
            end
            DCP_SPACE_PROG:
            begin
               d.pin.ps_n   = 1'b0;
               d.pin.strb_n = 1'b0;
            end
            DCP_SPACE_IO:
            begin
               d.pin.is_n   = 1'b0;
            end
            default:
            begin
               d.pin = DCP_SEL_IDLE;
            end
         endcase
      end
      d.oe = !hold && !out_en_n;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= {DCP_SEL_IDLE, 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign bus = q;

endmodule

// File: rtl/dcp_control_pins.sv
// Function
// - nmi ignores global mask and mask register
// - nmi traps program flow to its vector
// - reset low stops execution, pc at ff80
// - reset release starts fetching at ff80
// - rom select low at reset maps rom
// - rom select high at reset removes rom
// - rom select sampled only during reset
// - software mode bit overrides reset rom mode
// - conditional executes only when branch input low
// - xc samples at decode, others at read
// - flag latched: set high, clear/load low
// - external flag resets high
// - flag tri-stated while output disable low
// - space selects low only during valid address
// - selects tri-stated in hold or output disable
// - memory strobe low for data/program access
// - strobe tri-stated in hold or output disable
`timescale 1ns/100ps

module dcp_control_pins
   import dcp_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // device pins in
   input  wire logic        RESET_IN_N,
   input  wire logic        ROM_MAP_SELECT,
   input  wire logic        NMI_IN_N,
   input  wire logic        BRANCH_CONDITION_IN_N,
   input  wire logic        OUTPUT_DISABLE_N,
   input  wire logic        HOLD_REQ_N,
   // core program flow
   input  wire logic        PC_ADVANCE,
   input  wire logic        PC_LOAD,
   input  wire logic [15:0] PC_TARGET,
   input  wire logic [15:0] FETCH_ADDR,
   output      logic [15:0] PROGRAM_COUNTER,
   output      logic        CORE_RUN,
   output      logic        NMI_TAKEN,
   // rom mapping mode
   input  wire logic        MODE_BIT_WR,
   input  wire logic        MODE_BIT_VAL,
   output      logic        ROM_MAPPED,
   output      logic        ROM_HIT,
   // branch condition sampling
   input  wire logic        XC_DECODE,
   input  wire logic        READ_PHASE,
   output      logic        XC_CONDITION_TRUE,
   output      logic        READ_CONDITION_TRUE,
   // external flag instructions
   input  wire logic        SET_STATUS_BIT_INSTR,
   input  wire logic        CLEAR_STATUS_BIT_INSTR,
   input  wire logic        STATUS_WORD_ONE_LOAD,
   output      logic        EXTERNAL_FLAG_OUT_O,
   output      logic        EXTERNAL_FLAG_OUT_OE,
   // external access request
   input  wire dcp_access_t ACCESS,
   // memory control pins out
   output      logic        DATA_SPACE_SEL_N_O,
   output      logic        DATA_SPACE_SEL_N_OE,
   output      logic        PROGRAM_SPACE_SEL_N_O,
   output      logic        PROGRAM_SPACE_SEL_N_OE,
   output      logic        IO_SPACE_SEL_N_O,
   output      logic        IO_SPACE_SEL_N_OE,
   output      logic        MEMORY_STROBE_N_O,
   output      logic        MEMORY_STROBE_N_OE,
   // bus surrender acknowledge
   output      logic        HOLD_ACK_N
);

   // ==========================================================================
   // state

   typedef struct packed
   {
      dcp_run_t    run;
      logic        run_ok;
      logic [15:0] pc;
      logic        nmi_prev;
      logic        nmi_pend;
      logic        nmi_taken;
      logic        rom_mapped;
      logic        rom_hit;
      logic        cond_xc;
      logic        cond_rd;
      logic        flag;
      logic        flag_oe;
      logic        hold_ack_n;
   } dcp_top_state_t;

   localparam dcp_top_state_t DCP_TOP_RESET =
   '{
      run:        DCP_RUN_RESET,
      run_ok:     1'b0,
      pc:         DCP_RESET_VECTOR,
      nmi_prev:   1'b1,
      nmi_pend:   1'b0,
      nmi_taken:  1'b0,
      rom_mapped: DCP_ROM_RESET,
      rom_hit:    1'b0,
      cond_xc:    1'b0,
      cond_rd:    1'b0,
      flag:       DCP_FLAG_RESET,
      flag_oe:    1'b0,
      hold_ack_n: 1'b1
   };

   dcp_top_state_t       q;
   dcp_top_state_t       d;
   logic [DCP_PIN_W-1:0] pin_s;
   logic                 nmi_edge;
   dcp_access_t          acc_gated;
   dcp_bus_out_t         bus;

   // ==========================================================================
   // functions

   function automatic logic in_rom(input logic [15:0] addr);
      in_rom = (addr >= DCP_ROM_BASE);
   endfunction

   // ==========================================================================
   // pin synchronisers; every pin is asynchronous to CLK

   dcp_sync #(
      .W       (DCP_PIN_W),
      .RST_VAL (DCP_PIN_IDLE)
   ) u_sync (
      .clk  (CLK),
      .rst  (RST),
      .pin  ({HOLD_REQ_N, OUTPUT_DISABLE_N, BRANCH_CONDITION_IN_N,
              NMI_IN_N, ROM_MAP_SELECT, RESET_IN_N}),
      .sync (pin_s)
   );

   // ==========================================================================
   // next state

   always_comb
   begin
      d           = q;
      d.nmi_taken = 1'b0;
      // falling edge, so a held-low nmi traps once
      nmi_edge    = q.nmi_prev && !pin_s[DCP_PIN_NMI_N];
      d.nmi_prev  = pin_s[DCP_PIN_NMI_N];
      // no mask term: neither the global mask nor the mask register gates it
      d.nmi_pend  = q.nmi_pend || nmi_edge;

      unique case (q.run)
         DCP_RUN_RESET:
         begin
            d.pc         = DCP_RESET_VECTOR;
            d.nmi_pend   = 1'b0;
            // the last level seen before release is the one that stands
            d.rom_mapped = !pin_s[DCP_PIN_ROM_SEL];
            if (pin_s[DCP_PIN_RESET_N])
            begin
               // pc already holds the reset vector for the first fetch
               d.run = DCP_RUN_EXEC;
            end
         end
         DCP_RUN_EXEC:
         begin
            if (q.nmi_pend)
            begin
               d.pc        = DCP_NMI_VECTOR;
               d.nmi_taken = 1'b1;
               // an edge in the same cycle stays pending
               d.nmi_pend  = nmi_edge;
            end
            else if (PC_LOAD)
            begin
               d.pc = PC_TARGET;
            end
            else if (PC_ADVANCE)
            begin
               d.pc = q.pc + 16'h0001;
            end
            if (MODE_BIT_WR)
            begin
               d.rom_mapped = !MODE_BIT_VAL;
            end
            // surrender only between accesses so no cycle is cut short
            if (!pin_s[DCP_PIN_HOLD_N] && !ACCESS.valid)
            begin
               d.run = DCP_RUN_HOLD;
            end
         end
         DCP_RUN_HOLD:
         begin
            if (pin_s[DCP_PIN_HOLD_N])
            begin
               d.run = DCP_RUN_EXEC;
            end
         end
         default:
         begin
            d.run = DCP_RUN_RESET;
         end
      endcase

      // pin reset overrides every state
      if (!pin_s[DCP_PIN_RESET_N])
      begin
         d.run       = DCP_RUN_RESET;
         d.pc        = DCP_RESET_VECTOR;
         d.nmi_pend  = 1'b0;
         d.nmi_taken = 1'b0;
      end
      d.run_ok     = (d.run == DCP_RUN_EXEC);
      d.hold_ack_n = (d.run != DCP_RUN_HOLD);

      d.rom_hit = q.rom_mapped && in_rom(FETCH_ADDR);

      // branch input low means condition true
      if (XC_DECODE)
      begin
         d.cond_xc = !pin_s[DCP_PIN_BRANCH_N];
      end
      if (READ_PHASE)
      begin
         d.cond_rd = !pin_s[DCP_PIN_BRANCH_N];
      end

      // set wins if both arrive together
      if (!pin_s[DCP_PIN_RESET_N])
      begin
         d.flag = DCP_FLAG_RESET;
      end
      else if (SET_STATUS_BIT_INSTR)
      begin
         d.flag = 1'b1;
      end
      else if (CLEAR_STATUS_BIT_INSTR || STATUS_WORD_ONE_LOAD)
      begin
         d.flag = 1'b0;
      end
      d.flag_oe = pin_s[DCP_PIN_OUT_EN_N];
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         q <= DCP_TOP_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================================
   // memory control pins

   always_comb
   begin
      acc_gated       = ACCESS;
      acc_gated.valid = ACCESS.valid && (q.run == DCP_RUN_EXEC);
   end

   dcp_bus_sel u_bus_sel (
      .clk      (CLK),
      .rst      (RST),
      .access   (acc_gated),
      .hold     (q.run == DCP_RUN_HOLD),
      .out_en_n (!pin_s[DCP_PIN_OUT_EN_N]),
      .bus      (bus)
   );

   // ==========================================================================
   // outputs

   assign PROGRAM_COUNTER        = q.pc;
   assign CORE_RUN               = q.run_ok;
   assign NMI_TAKEN              = q.nmi_taken;
   assign ROM_MAPPED             = q.rom_mapped;
   assign ROM_HIT                = q.rom_hit;
   assign XC_CONDITION_TRUE      = q.cond_xc;
   assign READ_CONDITION_TRUE    = q.cond_rd;
   assign EXTERNAL_FLAG_OUT_O    = q.flag;
   assign EXTERNAL_FLAG_OUT_OE   = q.flag_oe;
   assign DATA_SPACE_SEL_N_O     = bus.pin.ds_n;
   assign DATA_SPACE_SEL_N_OE    = bus.oe;
   assign PROGRAM_SPACE_SEL_N_O  = bus.pin.ps_n;
   assign PROGRAM_SPACE_SEL_N_OE = bus.oe;
   assign IO_SPACE_SEL_N_O       = bus.pin.is_n;
   assign IO_SPACE_SEL_N_OE      = bus.oe;
   assign MEMORY_STROBE_N_O      = bus.pin.strb_n;
   assign MEMORY_STROBE_N_OE     = bus.oe;
   assign HOLD_ACK_N             = q.hold_ack_n;

endmodule

// File: test/dcp_control_pins_properties.sv
`timescale 1ns/100ps

module dcp_control_pins_properties
   import dcp_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // pins and core requests
   input  wire logic        RESET_IN_N,
   input  wire logic        OUTPUT_DISABLE_N,
   input  wire logic        BRANCH_CONDITION_IN_N,
   input  wire logic        XC_DECODE,
   input  wire logic        MODE_BIT_WR,
   input  wire logic        MODE_BIT_VAL,
   input  wire logic        SET_STATUS_BIT_INSTR,
   input  wire logic        CLEAR_STATUS_BIT_INSTR,
   input  wire dcp_access_t ACCESS,
   // outputs
   input  wire logic [15:0] PROGRAM_COUNTER,
   input  wire logic        CORE_RUN,
   input  wire logic        NMI_TAKEN,
   input  wire logic        ROM_MAPPED,
   input  wire logic        XC_CONDITION_TRUE,
   input  wire logic        EXTERNAL_FLAG_OUT_O,
   input  wire logic        EXTERNAL_FLAG_OUT_OE,
   input  wire logic        DATA_SPACE_SEL_N_O,
   input  wire logic        DATA_SPACE_SEL_N_OE,
   input  wire logic        IO_SPACE_SEL_N_O,
   input  wire logic        MEMORY_STROBE_N_O,
   input  wire logic        MEMORY_STROBE_N_OE,
   input  wire logic        HOLD_ACK_N
);
   // ==========================================================================
   // running and no pin reset on its way through the synchroniser
   logic [1:0] rst_pin_q;
   logic       live;
   always_ff @(posedge CLK)
      rst_pin_q <= {rst_pin_q[0], RESET_IN_N};
   assign live = CORE_RUN && rst_pin_q[1];

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // ==========================================================================
   // assertions
   chk_nmi_vector: assert property (NMI_TAKEN |-> PROGRAM_COUNTER == DCP_NMI_VECTOR)
      else $error("nmi pulse without its vector");
   chk_reset_pc: assert property (!CORE_RUN && HOLD_ACK_N |-> PROGRAM_COUNTER == DCP_RESET_VECTOR)
      else $error("stopped pc off reset vector");
   chk_run_start: assert property ($rose(CORE_RUN) && $past(HOLD_ACK_N) |-> PROGRAM_COUNTER == DCP_RESET_VECTOR)
      else $error("execution not started at reset vector");
   chk_rom_frozen: assert property ($past(CORE_RUN) && CORE_RUN && !$past(MODE_BIT_WR) |-> $stable(ROM_MAPPED))
      else $error("rom mode moved while running");
   chk_mode_write: assert property (MODE_BIT_WR && live |=> ROM_MAPPED == !$past(MODE_BIT_VAL))
      else $error("mode bit write not applied");
   chk_branch_xc: assert property (XC_DECODE && CORE_RUN |=> XC_CONDITION_TRUE == !$past(BRANCH_CONDITION_IN_N, 3))
      else $error("decode sample of branch pin wrong");
   chk_flag_set: assert property (SET_STATUS_BIT_INSTR |=> EXTERNAL_FLAG_OUT_O)
      else $error("flag not set");
   chk_flag_clear: assert property (CLEAR_STATUS_BIT_INSTR && !SET_STATUS_BIT_INSTR && live |=> !EXTERNAL_FLAG_OUT_O)
      else $error("flag not cleared");
   chk_flag_float: assert property (!$past(OUTPUT_DISABLE_N, 3) |-> !EXTERNAL_FLAG_OUT_OE)
      else $error("flag driven while outputs disabled");
   chk_strb_data: assert property (ACCESS.valid && ACCESS.space == DCP_SPACE_DATA && live |=> !DATA_SPACE_SEL_N_O && !MEMORY_STROBE_N_O)
      else $error("data access without select and strobe");
   chk_io_nostrb: assert property (ACCESS.valid && ACCESS.space == DCP_SPACE_IO && live |=> !IO_SPACE_SEL_N_O && MEMORY_STROBE_N_O && DATA_SPACE_SEL_N_O)
      else $error("io access pins wrong");
   chk_sel_idle: assert property (!ACCESS.valid && live |=> DATA_SPACE_SEL_N_O && IO_SPACE_SEL_N_O && MEMORY_STROBE_N_O)
      else $error("select low without access");
   chk_hold_float: assert property (!HOLD_ACK_N |=> !DATA_SPACE_SEL_N_OE && !MEMORY_STROBE_N_OE)
      else $error("pins driven in hold");

   cov_nmi: cover property (NMI_TAKEN);
   cov_hold: cover property (!HOLD_ACK_N);
   cov_xc_true: cover property (XC_DECODE && CORE_RUN ##1 XC_CONDITION_TRUE);
endmodule

bind dcp_control_pins dcp_control_pins_properties u_props (.CLK, .RST, .RESET_IN_N,
   .OUTPUT_DISABLE_N, .BRANCH_CONDITION_IN_N, .XC_DECODE, .MODE_BIT_WR, .MODE_BIT_VAL,
   .SET_STATUS_BIT_INSTR, .CLEAR_STATUS_BIT_INSTR, .ACCESS, .PROGRAM_COUNTER, .CORE_RUN,
   .NMI_TAKEN, .ROM_MAPPED, .XC_CONDITION_TRUE, .EXTERNAL_FLAG_OUT_O, .EXTERNAL_FLAG_OUT_OE,
   .DATA_SPACE_SEL_N_O, .DATA_SPACE_SEL_N_OE, .IO_SPACE_SEL_N_O, .MEMORY_STROBE_N_O,
   .MEMORY_STROBE_N_OE, .HOLD_ACK_N);

// File: test/dcp_ext_bus_model.sv
`timescale 1ns/100ps

module dcp_ext_bus_model
   import dcp_pkg::*;
(
   // clock and bus wish from the bench
   input  wire logic     clk,
   input  wire logic     want_bus,
   // memory control pins of the device
   input  wire dcp_sel_t pin_o,
   input  wire dcp_sel_t pin_oe,
   // surrender request and resolved line levels
   output logic          hold_req_n,
   output dcp_sel_t      line
);
   dcp_sel_t last_q;
   initial hold_req_n = 1'b1;
   initial last_q = DCP_SEL_IDLE;
   // no pull-ups here: a released line flips so a stale level never passes
   always @(posedge clk)
   begin
      hold_req_n <= !want_bus;
      last_q <= dcp_sel_t'((pin_oe & pin_o) | (~pin_oe & last_q));
   end
   assign line = dcp_sel_t'((pin_oe & pin_o) | (~pin_oe & ~last_q));
endmodule

// File: test/tb_dcp_control_pins.sv
`timescale 1ns/100ps

module tb_dcp_control_pins;
   import dcp_pkg::*;
   // ==========================================================================
   // pins
   logic        CLK = 1'b0, RST = 1'b1, RESET_IN_N = 1'b1, ROM_MAP_SELECT = 1'b0;
   logic        NMI_IN_N = 1'b1, BRANCH_CONDITION_IN_N = 1'b1, OUTPUT_DISABLE_N = 1'b1;
   logic        PC_ADVANCE = 1'b0, PC_LOAD = 1'b0, MODE_BIT_WR = 1'b0, MODE_BIT_VAL = 1'b0;
   logic        XC_DECODE = 1'b0, READ_PHASE = 1'b0, want_bus = 1'b0, HOLD_REQ_N;
   logic        SET_STATUS_BIT_INSTR = 1'b0, CLEAR_STATUS_BIT_INSTR = 1'b0;
   logic        STATUS_WORD_ONE_LOAD = 1'b0;
   logic [15:0] PC_TARGET = 16'h0, FETCH_ADDR = 16'h0, PROGRAM_COUNTER;
   dcp_access_t ACCESS = '0;
   dcp_sel_t    line;
   logic        CORE_RUN, NMI_TAKEN, ROM_MAPPED, ROM_HIT, XC_CONDITION_TRUE;
   logic        READ_CONDITION_TRUE, EXTERNAL_FLAG_OUT_O, EXTERNAL_FLAG_OUT_OE, HOLD_ACK_N;
   logic        DATA_SPACE_SEL_N_O, DATA_SPACE_SEL_N_OE, PROGRAM_SPACE_SEL_N_O;
   logic        PROGRAM_SPACE_SEL_N_OE, IO_SPACE_SEL_N_O, IO_SPACE_SEL_N_OE;
   logic        MEMORY_STROBE_N_O, MEMORY_STROBE_N_OE;
   int          err_total = 0, tests_run = 0, cycles = 0;

   dcp_control_pins u_dut (.CLK, .RST, .RESET_IN_N, .ROM_MAP_SELECT, .NMI_IN_N,
      .BRANCH_CONDITION_IN_N, .OUTPUT_DISABLE_N, .HOLD_REQ_N, .PC_ADVANCE, .PC_LOAD,
      .PC_TARGET, .FETCH_ADDR, .PROGRAM_COUNTER, .CORE_RUN, .NMI_TAKEN, .MODE_BIT_WR,
      .MODE_BIT_VAL, .ROM_MAPPED, .ROM_HIT, .XC_DECODE, .READ_PHASE, .XC_CONDITION_TRUE,
      .READ_CONDITION_TRUE, .SET_STATUS_BIT_INSTR, .CLEAR_STATUS_BIT_INSTR,
      .STATUS_WORD_ONE_LOAD, .EXTERNAL_FLAG_OUT_O, .EXTERNAL_FLAG_OUT_OE, .ACCESS,
      .DATA_SPACE_SEL_N_O, .DATA_SPACE_SEL_N_OE, .PROGRAM_SPACE_SEL_N_O,
      .PROGRAM_SPACE_SEL_N_OE, .IO_SPACE_SEL_N_O, .IO_SPACE_SEL_N_OE, .MEMORY_STROBE_N_O,
      .MEMORY_STROBE_N_OE, .HOLD_ACK_N);

   dcp_ext_bus_model u_bus (.clk(CLK), .want_bus, .hold_req_n(HOLD_REQ_N), .line,
      .pin_o({DATA_SPACE_SEL_N_O, PROGRAM_SPACE_SEL_N_O, IO_SPACE_SEL_N_O, MEMORY_STROBE_N_O}),
      .pin_oe({DATA_SPACE_SEL_N_OE, PROGRAM_SPACE_SEL_N_OE, IO_SPACE_SEL_N_OE,
               MEMORY_STROBE_N_OE}));

   always #2.5 CLK = ~CLK;

   // ==========================================================================
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_flag();
      CLEAR_STATUS_BIT_INSTR = 1'b1;
      tick(1);
      CLEAR_STATUS_BIT_INSTR = 1'b0;
      chk(EXTERNAL_FLAG_OUT_O === 1'b0, "flag clear");
      SET_STATUS_BIT_INSTR = 1'b1;
      tick(1);
      SET_STATUS_BIT_INSTR = 1'b0;
      chk(EXTERNAL_FLAG_OUT_O === 1'b1, "flag set");
      STATUS_WORD_ONE_LOAD = 1'b1;
      tick(1);
      STATUS_WORD_ONE_LOAD = 1'b0;
      chk(EXTERNAL_FLAG_OUT_O === 1'b0, "flag load");
      OUTPUT_DISABLE_N = 1'b0;
      tick(4);
      chk(EXTERNAL_FLAG_OUT_OE === 1'b0 && line === ~DCP_SEL_IDLE, "outputs float");
      OUTPUT_DISABLE_N = 1'b1;
      tick(4);
      chk(EXTERNAL_FLAG_OUT_OE === 1'b1 && line === DCP_SEL_IDLE, "outputs back");
   endtask

   task automatic t_rom();
      ROM_MAP_SELECT = 1'b1;
      FETCH_ADDR = DCP_ROM_BASE;
      tick(5);
      chk(ROM_MAPPED === 1'b1 && ROM_HIT === 1'b1, "rom mode moved");
      FETCH_ADDR = 16'hbfff;
      RESET_IN_N = 1'b0;
      tick(5);
      chk(ROM_HIT === 1'b0 && ROM_MAPPED === 1'b0, "rom not removed");
      chk(!CORE_RUN && PROGRAM_COUNTER === DCP_RESET_VECTOR, "pin reset");
      chk(EXTERNAL_FLAG_OUT_O === 1'b1, "flag reset value");
      ROM_MAP_SELECT = 1'b0;
      tick(4);
      chk(ROM_MAPPED === 1'b1, "rom not mapped");
      RESET_IN_N = 1'b1;
      tick(4);
      chk(CORE_RUN === 1'b1 && PROGRAM_COUNTER === DCP_RESET_VECTOR, "restart");
      MODE_BIT_WR = 1'b1;
      MODE_BIT_VAL = 1'b1;
      tick(1);
      MODE_BIT_WR = 1'b0;
      chk(ROM_MAPPED === 1'b0, "mode bit write");
   endtask

   task automatic t_pc_nmi();
      int i;
      PC_LOAD = 1'b1;
      PC_ADVANCE = 1'b1;
      PC_TARGET = 16'h1234;
      tick(1);
      PC_LOAD = 1'b0;
      tick(1);
      PC_ADVANCE = 1'b0;
      chk(PROGRAM_COUNTER === 16'h1235, "pc load then advance");
      NMI_IN_N = 1'b0;
      for (i = 0; i < 8 && NMI_TAKEN !== 1'b1; i++)
         tick(1);
      NMI_IN_N = 1'b1;
      chk(NMI_TAKEN === 1'b1 && PROGRAM_COUNTER === DCP_NMI_VECTOR, "nmi trap");
   endtask

   task automatic t_branch();
      for (int v = 0; v < 2; v++)
      begin
         BRANCH_CONDITION_IN_N = 1'(v);
         tick(3);
         XC_DECODE = 1'b1;
         tick(1);
         XC_DECODE = 1'b0;
         READ_PHASE = 1'b1;
         chk(XC_CONDITION_TRUE === 1'(v == 0), "decode sample");
         tick(1);
         READ_PHASE = 1'b0;
         chk(READ_CONDITION_TRUE === 1'(v == 0), "read sample");
      end
      // each sampling point keeps its own level until its own phase comes again
      BRANCH_CONDITION_IN_N = 1'b0;
      tick(3);
      READ_PHASE = 1'b1;
      tick(1);
      READ_PHASE = 1'b0;
      chk(READ_CONDITION_TRUE === 1'b1 && XC_CONDITION_TRUE === 1'b0, "sample points");
   endtask

   task automatic t_bus();
      int i;
      for (int s = 0; s < 3; s++)
      begin
         ACCESS = '{valid: 1'b1, space: dcp_space_t'(s)};
         tick(1);
         chk(line === dcp_sel_t'({~(3'h4 >> s), 1'(s == 2)}), "select pins");
      end
      ACCESS.valid = 1'b0;
      tick(1);
      chk(line === DCP_SEL_IDLE, "selects idle");
      want_bus = 1'b1;
      for (i = 0; i < 10 && HOLD_ACK_N !== 1'b0; i++)
         tick(1);
      ACCESS = '{valid: 1'b1, space: DCP_SPACE_PROG};
      tick(1);
      chk(!HOLD_ACK_N && !CORE_RUN && line === ~DCP_SEL_IDLE, "hold float");
      ACCESS.valid = 1'b0;
      want_bus = 1'b0;
      tick(6);
      chk(HOLD_ACK_N === 1'b1 && line === DCP_SEL_IDLE, "hold exit");
   endtask

   // ==========================================================================
   // main sequence and hang guard
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_total++;
         end_of_test();
      end
   end

   initial
   begin
      tick(5);
      RST = 1'b0;
      tick(4);
      chk(CORE_RUN && PROGRAM_COUNTER === DCP_RESET_VECTOR, "boot");
      chk(EXTERNAL_FLAG_OUT_O === DCP_FLAG_RESET && ROM_MAPPED === 1'b1, "boot pins");
      t_flag();
      t_rom();
      t_pc_nmi();
      t_branch();
      t_bus();
      end_of_test();
   end
endmodule
